// *** logic/rtc_pkg.sv ***
// Purpose: Shared constants and types for the real-time clock core
// Assumes: 32-bit AXI4-Lite register window, 8-bit byte address
// Notes: Offsets are byte addresses of aligned words
package rtc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_TIME = 8'h00;
  localparam logic [7:0] OFS_DATE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_PRESC = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_SUBSEC = 8'h18;
  localparam logic [7:0] OFS_ALM_A_TIME = 8'h1c;
  localparam logic [7:0] OFS_ALM_B_TIME = 8'h20;
  localparam logic [7:0] OFS_ALM_A_SS = 8'h24;
  localparam logic [7:0] OFS_ALM_B_SS = 8'h28;
  localparam logic [7:0] OFS_ALM_A_BIN = 8'h2c;
  localparam logic [7:0] OFS_ALM_B_BIN = 8'h30;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_INIT = 0;
  localparam int CTRL_READY = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_INC = 4;
  localparam int CTRL_BYPASS = 7;
  localparam int CTRL_EN = 8;
  localparam int CTRL_IE = 10;
  localparam int CTRL_OUT_EN = 12;
  localparam int CTRL_OUT_POL = 13;
  localparam int CTRL_OUT_SEL = 14;
  localparam int STAT_FLAG = 0;
  localparam int STAT_WA = 2;
  localparam int PRESC_ASYNC = 16;
  localparam int ALM_IGN_SEC = 7;
  localparam int ALM_IGN_MIN = 15;
  localparam int ALM_IGN_HOUR = 23;
  localparam int ALM_IGN_DAY = 31;
  localparam int ALM_DATE = 24;
  localparam int ALM_SS_USE = 31;
  // ------------------------------------------------------------
  // Values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'hca;
  localparam logic [7:0] KEY_SECOND = 8'h53;
  localparam logic [7:0] KEY_RELOCK = 8'hff;
  localparam logic [6:0] ASYNC_RST = 7'h7f;
  localparam logic [14:0] SYNC_RST = 15'h00ff;
  localparam logic [31:0] SS_RELOAD = 32'hffff_ffff;
  localparam logic [1:0] SYNC_KTICKS = 2'h2;
  localparam logic [5:0] DATE_RST = 6'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MODE_BCD = 2'b00, MODE_BINARY = 2'b01,
    MODE_MIXED = 2'b11, MODE_MIXED_ALT = 2'b10} bin_mode_t;
  typedef enum logic [1:0] {KEY_LOCKED = 2'b00, KEY_HALF = 2'b01,
    KEY_OPEN = 2'b11, KEY_BAD = 2'b10} key_state_t;
endpackage : rtc_pkg

// *** logic/rtc_core.sv ***
// Purpose: Real-time clock core with prescalers, binary/mixed modes, two alarms
// Assumes: kernel_clock is a slow pin sampled on clk_sys (100 MHz)
// Notes: All state sits in one struct registered by one process
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module rtc_core (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Kernel clock pin
  input wire logic kernel_clock,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events
  output logic calendar_tick,
  output logic alarm_a_irq,
  output logic alarm_b_irq,
  output logic alarm_wakeup,
  output logic alarm_out
);
  typedef struct packed {
    logic [1:0] ksync;
    logic kprev;
    rtc_pkg::key_state_t key;
    logic init;
    logic ready;
    logic [1:0] init_cnt;
    rtc_pkg::bin_mode_t mode;
    logic [2:0] inc_sel;
    logic bypass;
    logic [1:0] en;
    logic [1:0] ie;
    logic [1:0] flag;
    logic [1:0] wa;
    logic [1:0][1:0] wa_cnt;
    logic out_en;
    logic out_pol;
    logic out_sel;
    logic out;
    logic [6:0] async_set;
    logic [6:0] async_cnt;
    logic [14:0] sync_set;
    logic [31:0] ss;
    logic [31:0] ss_shadow;
    logic [22:0] time_r;
    logic [22:0] time_shadow;
    logic [5:0] date;
    logic [5:0] date_shadow;
    logic [1:0][31:0] alm_time;
    logic [1:0][31:0] alm_ss;
    logic [1:0][31:0] alm_bin;
    logic apre_tick;
    logic sec_tick;
    logic upd;
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t d;
  logic ktick;
  logic do_wr;
  logic prot_ok;
  logic [31:0] wv;
  logic [31:0] inc_mask;
  logic [31:0] ss_nxt;
  logic sec;
  logic [1:0] match;
  logic [1:0] trig;
  logic [1:0] clr;
  logic [1:0] alm_wr;
  logic [8:0] step;

  // ------------------------------------------------------------
  // BCD and byte-merge helpers
  // ------------------------------------------------------------
  // Returns {wrap, next}; wraps from top back to first
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
    input logic [7:0] first);
    logic [8:0] r;
    r = {1'b0, v};
    if (v == top)
      r = {1'b1, first};
    else if (v[3:0] == 4'h9)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_step

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : wmerge

  // ------------------------------------------------------------
  // Alarm match, one unit per alarm
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_alarm
    logic m_ss;
    logic m_cal;
    // Binary mode has no calendar, so only the subsecond part counts
    assign m_ss = !q.alm_ss[i][rtc_pkg::ALM_SS_USE] ||
      ((q.mode == rtc_pkg::MODE_BCD) ? (q.ss[14:0] == q.alm_ss[i][14:0])
      : (q.ss == q.alm_bin[i]));
    assign m_cal = (q.mode == rtc_pkg::MODE_BINARY) ||
      ((q.alm_time[i][rtc_pkg::ALM_IGN_SEC] || q.time_r[6:0] == q.alm_time[i][6:0]) &&
      (q.alm_time[i][rtc_pkg::ALM_IGN_MIN] || q.time_r[14:8] == q.alm_time[i][14:8]) &&
      (q.alm_time[i][rtc_pkg::ALM_IGN_HOUR] || q.time_r[22:16] == q.alm_time[i][22:16]) &&
      (q.alm_time[i][rtc_pkg::ALM_IGN_DAY] || q.date == q.alm_time[i][29:24]));
    assign match[i] = m_ss && m_cal;
    // Without a subsecond term the alarm is checked once per second
    assign trig[i] = q.alm_ss[i][rtc_pkg::ALM_SS_USE] ? 1'b1 : q.sec_tick;
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // One pass covers sync, prescaler, calendar, alarms and the bus
  always_comb
  begin
    d = q;
    d.apre_tick = 1'b0;
    d.sec_tick = 1'b0;
    d.upd = 1'b0;
    sec = 1'b0;
    step = 9'h000;
    clr = 2'b00;
    alm_wr = 2'b00;
    d.ksync = {q.ksync[0], kernel_clock};
    d.kprev = q.ksync[1];
    ktick = q.ksync[1] && !q.kprev;
    inc_mask = ~(32'hffff_ffff << (32'(q.inc_sel) + 32'd1));
    ss_nxt = (q.ss == 32'h0) ? rtc_pkg::SS_RELOAD : q.ss - 32'h1;
    // Init handshake needs two kernel edges, like a real crossing
    if (!q.init)
    begin
      d.ready = 1'b0;
      d.init_cnt = 2'h0;
    end
    else if (ktick && !q.ready)
    begin
      if (q.init_cnt == rtc_pkg::SYNC_KTICKS - 2'h1)
        d.ready = 1'b1;
      else
        d.init_cnt = q.init_cnt + 2'h1;
    end
    // Write-allowed follows disable after two kernel edges
    for (int i = 0; i < 2; i++)
    begin
      if (q.en[i])
      begin
        d.wa[i] = 1'b0;
        d.wa_cnt[i] = 2'h0;
      end
      else if (ktick && !q.wa[i])
      begin
        if (q.wa_cnt[i] == rtc_pkg::SYNC_KTICKS - 2'h1)
          d.wa[i] = 1'b1;
        else
          d.wa_cnt[i] = q.wa_cnt[i] + 2'h1;
      end
    end
    // Asynchronous divider; stopped in init so counting resumes cleanly
    if (!q.init && ktick)
    begin
      if (q.async_cnt == 7'h0)
      begin
        d.async_cnt = q.async_set;
        d.apre_tick = 1'b1;
      end
      else
        d.async_cnt = q.async_cnt - 7'h1;
    end
    // Synchronous divider or binary counter
    if (q.apre_tick && !q.init)
    begin
      d.upd = 1'b1;
      if (q.mode == rtc_pkg::MODE_BCD)
      begin
        if (q.ss[14:0] == 15'h0)
        begin
          d.ss = {17'h0, q.sync_set};
          sec = 1'b1;
        end
        else
          d.ss = q.ss - 32'h1;
      end
      else
      begin
        d.ss = ss_nxt;
        sec = (q.mode != rtc_pkg::MODE_BINARY) && ((ss_nxt & inc_mask) == 32'h0);
      end
    end
    d.sec_tick = sec;
    // Calendar in BCD; binary mode leaves it frozen
    if (sec && q.mode != rtc_pkg::MODE_BINARY)
    begin
      step = bcd_step({1'b0, q.time_r[6:0]}, 8'h59, 8'h00);
      d.time_r[6:0] = step[6:0];
      if (step[8])
      begin
        step = bcd_step({1'b0, q.time_r[14:8]}, 8'h59, 8'h00);
        d.time_r[14:8] = step[6:0];
        if (step[8])
        begin
          step = bcd_step({2'b00, q.time_r[21:16]}, 8'h23, 8'h00);
          d.time_r[21:16] = step[5:0];
          if (step[8])
          begin
            step = bcd_step({2'b00, q.date}, 8'h31, 8'h01);
            d.date = step[5:0];
          end
        end
      end
    end
    // Shadows follow the live counters after each update and during init
    if (q.upd || q.init)
    begin
      d.ss_shadow = q.ss;
      d.time_shadow = q.time_r;
      d.date_shadow = q.date;
    end
    // AXI write channels are taken in either order
    if (s_axi_awvalid && !q.aw_full)
    begin
      d.aw_full = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_full)
    begin
      d.w_full = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    do_wr = q.aw_full && q.w_full && !q.bvalid;
    prot_ok = q.key == rtc_pkg::KEY_OPEN;
    wv = 32'h0;
    if (do_wr)
    begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = rtc_pkg::RESP_OKAY;
      // Locked writes finish with OKAY and change nothing but the key state and the status flag clears
      unique case ({q.awaddr[7:2], 2'b00})
        rtc_pkg::OFS_KEY:
          if (q.wstrb[0])
          begin
            if (q.wdata[7:0] == rtc_pkg::KEY_FIRST)
              d.key = rtc_pkg::KEY_HALF;
            else if (q.key == rtc_pkg::KEY_HALF && q.wdata[7:0] == rtc_pkg::KEY_SECOND)
              d.key = rtc_pkg::KEY_OPEN;
            else
              d.key = rtc_pkg::KEY_LOCKED;
          end
        rtc_pkg::OFS_STAT:
          if (q.wstrb[0])
            clr = q.wdata[rtc_pkg::STAT_FLAG +: 2];
        rtc_pkg::OFS_CTRL:
          if (prot_ok)
          begin
            wv = wmerge({17'h0, q.out_sel, q.out_pol, q.out_en, q.ie, q.en, q.bypass,
              q.inc_sel, q.mode, q.ready, q.init}, q.wdata, q.wstrb);
            d.init = wv[rtc_pkg::CTRL_INIT];
            d.bypass = wv[rtc_pkg::CTRL_BYPASS];
            d.en = wv[rtc_pkg::CTRL_EN +: 2];
            d.ie = wv[rtc_pkg::CTRL_IE +: 2];
            d.out_en = wv[rtc_pkg::CTRL_OUT_EN];
            d.out_pol = wv[rtc_pkg::CTRL_OUT_POL];
            d.out_sel = wv[rtc_pkg::CTRL_OUT_SEL];
            if (q.init)
            begin
              d.mode = rtc_pkg::bin_mode_t'(wv[rtc_pkg::CTRL_MODE +: 2]);
              d.inc_sel = wv[rtc_pkg::CTRL_INC +: 3];
              if (wv[rtc_pkg::CTRL_MODE +: 2] == rtc_pkg::MODE_BINARY)
                d.ss = rtc_pkg::SS_RELOAD;
            end
          end
        rtc_pkg::OFS_PRESC:
          if (prot_ok && q.init)
          begin
            wv = wmerge({9'h0, q.async_set, 1'b0, q.sync_set}, q.wdata, q.wstrb);
            d.async_set = wv[rtc_pkg::PRESC_ASYNC +: 7];
            d.sync_set = wv[14:0];
            d.async_cnt = wv[rtc_pkg::PRESC_ASYNC +: 7];
            d.ss = {17'h0, wv[14:0]};
          end
        rtc_pkg::OFS_TIME:
          if (prot_ok && q.init)
            d.time_r = 23'(wmerge({9'h0, q.time_r}, q.wdata, q.wstrb) & 32'h007f_7f7f);
        rtc_pkg::OFS_DATE:
          if (prot_ok && q.init)
            d.date = 6'(wmerge({26'h0, q.date}, q.wdata, q.wstrb) & 32'h3f);
        rtc_pkg::OFS_ALM_A_TIME, rtc_pkg::OFS_ALM_B_TIME,
        rtc_pkg::OFS_ALM_A_SS, rtc_pkg::OFS_ALM_B_SS,
        rtc_pkg::OFS_ALM_A_BIN, rtc_pkg::OFS_ALM_B_BIN:
        begin
          // Even slots are alarm B, odd slots alarm A
          alm_wr[q.awaddr[2] ? 0 : 1] = prot_ok && (q.init || q.wa[q.awaddr[2] ? 0 : 1]);
          for (int i = 0; i < 2; i++)
            if (alm_wr[i])
            begin
              if (q.awaddr[7:4] == 4'h1 || q.awaddr == rtc_pkg::OFS_ALM_B_TIME)
                d.alm_time[i] = wmerge(q.alm_time[i], q.wdata, q.wstrb) & 32'hbfff_ffff;
              else if (q.awaddr[7:2] < rtc_pkg::OFS_ALM_A_BIN[7:2])
                d.alm_ss[i] = wmerge(q.alm_ss[i], q.wdata, q.wstrb) & 32'h8000_7fff;
              else
                d.alm_bin[i] = wmerge(q.alm_bin[i], q.wdata, q.wstrb);
            end
        end
        rtc_pkg::OFS_SUBSEC:
        begin
        end
        default:
          d.bresp = rtc_pkg::RESP_SLVERR;
      endcase
    end
    // Flags: clear first so a match in the same cycle wins
    for (int i = 0; i < 2; i++)
    begin
      if (clr[i])
        d.flag[i] = 1'b0;
      if (q.upd && q.en[i] && trig[i] && match[i])
        d.flag[i] = 1'b1;
    end
    d.out = (q.out_en && (q.out_sel ? q.flag[1] : q.flag[0])) ^ q.out_pol;
    // Read channel, one outstanding read
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp = rtc_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        rtc_pkg::OFS_TIME: d.rdata = {9'h0, q.bypass ? q.time_r : q.time_shadow};
        rtc_pkg::OFS_DATE: d.rdata = {26'h0, q.bypass ? q.date : q.date_shadow};
        rtc_pkg::OFS_CTRL: d.rdata = {17'h0, q.out_sel, q.out_pol, q.out_en, q.ie, q.en, q.bypass,
          q.inc_sel, q.mode, q.ready, q.init};
        rtc_pkg::OFS_STAT: d.rdata = {28'h0, q.wa, q.flag};
        rtc_pkg::OFS_PRESC: d.rdata = {9'h0, q.async_set, 1'b0, q.sync_set};
        rtc_pkg::OFS_KEY: d.rdata = 32'h0;
        rtc_pkg::OFS_SUBSEC: d.rdata = q.bypass ? q.ss : q.ss_shadow;
        rtc_pkg::OFS_ALM_A_TIME: d.rdata = q.alm_time[0];
        rtc_pkg::OFS_ALM_B_TIME: d.rdata = q.alm_time[1];
        rtc_pkg::OFS_ALM_A_SS: d.rdata = q.alm_ss[0];
        rtc_pkg::OFS_ALM_B_SS: d.rdata = q.alm_ss[1];
        rtc_pkg::OFS_ALM_A_BIN: d.rdata = q.alm_bin[0];
        rtc_pkg::OFS_ALM_B_BIN: d.rdata = q.alm_bin[1];
        default:
        begin
          d.rdata = 32'h0;
          d.rresp = rtc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
      q.key <= rtc_pkg::KEY_LOCKED;
      q.mode <= rtc_pkg::MODE_BCD;
      q.wa <= 2'b11;
      q.async_set <= rtc_pkg::ASYNC_RST;
      q.async_cnt <= rtc_pkg::ASYNC_RST;
      q.sync_set <= rtc_pkg::SYNC_RST;
      q.ss <= {17'h0, rtc_pkg::SYNC_RST};
      q.date <= rtc_pkg::DATE_RST;
    end
    else
      q <= d;
  end

  // Outputs
  assign s_axi_awready = !q.aw_full;
  assign s_axi_wready = !q.w_full;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign calendar_tick = q.sec_tick;
  assign alarm_a_irq = q.flag[0] && q.ie[0];
  assign alarm_b_irq = q.flag[1] && q.ie[1];
  assign alarm_wakeup = alarm_a_irq || alarm_b_irq;
  assign alarm_out = q.out;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Neither half open nor open: the very next state must not be open
  sequence s_shut;
    q.key != rtc_pkg::KEY_HALF && q.key != rtc_pkg::KEY_OPEN;
  endsequence
  chk_key_order: assert property (s_shut |=> q.key != rtc_pkg::KEY_OPEN)
    else $error("unlock without first key");
  chk_locked_alarm: assert property (do_wr && !prot_ok |=> $stable(q.alm_time) && $stable(q.sync_set))
    else $error("locked write changed a register");
  chk_alarm_guard: assert property (!alm_wr[0] && !alm_wr[1] |=> $stable(q.alm_bin))
    else $error("alarm register changed while guarded");
  chk_wa_enabled: assert property (q.en[0] |=> !q.wa[0])
    else $error("write allowed while alarm enabled");
  chk_bcd_reload: assert property (q.apre_tick && !q.init && q.mode == rtc_pkg::MODE_BCD && q.ss[14:0] == 15'h0
    |=> q.sec_tick && q.ss == {17'h0, $past(q.sync_set)})
    else $error("sync divider did not reload");
  chk_bin_wrap: assert property (q.apre_tick && !q.init && q.mode != rtc_pkg::MODE_BCD && q.ss == 32'h0
    |=> q.ss == rtc_pkg::SS_RELOAD)
    else $error("binary counter did not reload");
  chk_bin_frozen: assert property (q.mode == rtc_pkg::MODE_BINARY && !q.init |=> $stable(q.time_r))
    else $error("calendar moved in binary mode");
  chk_flag_set: assert property (q.upd && q.en[0] && trig[0] && match[0] |=> q.flag[0] ##1 q.flag[0] || $past(clr[0]))
    else $error("alarm flag not set on match");
  chk_flag_hold: assert property (q.flag[1] && !clr[1] |=> q.flag[1])
    else $error("alarm flag dropped without clear");
  chk_ready_wait: assert property ($rose(q.init) |-> !q.ready [*2])
    else $error("init ready too early");
endmodule : rtc_core

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the real-time clock core over AXI4-Lite
// Assumes: Kernel clock made from clk_sys at one eighth rate, small divider settings
// Notes: Bus signals change by non-blocking assignment just after rising edges
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0, rst = 1'b1, kernel_clock = 1'b0;
  logic [2:0] kdiv_q = 3'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, calendar_tick, irq_a, irq_b, wakeup, alarm_out;
  logic [1:0] bresp, rresp;
  int err_total = 0, checks_done = 0;
  // ------------------------------------------------------------
  // Clock, kernel clock and design
  // ------------------------------------------------------------
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Kernel clock period of 8 cycles keeps each level well above two cycles
  always @(posedge clk_sys)
  begin
    kdiv_q <= kdiv_q + 3'h1;
    kernel_clock <= kdiv_q[2];
  end
  rtc_core rtc_core_i (.clk_sys(clk_sys), .rst(rst), .kernel_clock(kernel_clock),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .calendar_tick(calendar_tick), .alarm_a_irq(irq_a), .alarm_b_irq(irq_b),
    .alarm_wakeup(wakeup), .alarm_out(alarm_out));
  // ------------------------------------------------------------
  // Reporting and bus tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks_done %0d err_total %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // A hang counts as a mismatch and ends the run at once
  task automatic give_up(input string what);
    $display("mismatch %s expected answer seen timeout", what);
    err_total++;
    report_and_stop();
  endtask : give_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  // Address and data offered together; bready and rready stay high between transfers
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_ok = 0, w_ok = 0, done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (100)
    begin
      @(posedge clk_sys);
      if (bvalid === 1'b1 && aw_ok && w_ok)
      begin
        resp = bresp;
        done = 1;
        break;
      end
      aw_ok = aw_ok | (awready === 1'b1);
      w_ok = w_ok | (wready === 1'b1);
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    if (!done)
      give_up("write");
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ar_ok = 0, done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (100)
    begin
      @(posedge clk_sys);
      if (rvalid === 1'b1 && ar_ok)
      begin
        d = rdata;
        resp = rresp;
        done = 1;
        break;
      end
      ar_ok = ar_ok | (arready === 1'b1);
      arvalid <= !ar_ok;
    end
    if (!done)
      give_up("read");
  endtask : axi_read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask : wr
  // Reads a register and compares it whole, response included
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(what, exp, d);
    chk("read response", {30'h0, rtc_pkg::RESP_OKAY}, {30'h0, r});
  endtask : rd_chk
  // Polls a masked register value with a bounded number of reads
  task automatic poll(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    repeat (50)
    begin
      axi_read(a, d, r);
      if ((d & m) === exp)
        return;
    end
    give_up(what);
  endtask : poll
  task automatic unlock;
    wr(rtc_pkg::OFS_KEY, {24'h0, rtc_pkg::KEY_FIRST});
    wr(rtc_pkg::OFS_KEY, {24'h0, rtc_pkg::KEY_SECOND});
  endtask : unlock
  // Cycles from one calendar tick to the next; a missing first tick ends the run
  task automatic tick_period(output int n);
    for (n = 0; n < 2000 && calendar_tick !== 1'b1; n++) @(posedge clk_sys);
    if (n == 2000)
      give_up("calendar tick");
    for (n = 1; n < 2000; n++)
    begin
      @(posedge clk_sys);
      if (calendar_tick === 1'b1)
        break;
    end
  endtask : tick_period
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic check_reset_state;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("prescaler reset", rtc_pkg::OFS_PRESC, 32'h007f_00ff);
    rd_chk("status reset", rtc_pkg::OFS_STAT, 32'h0000_000c);
    axi_read(8'h3c, d, r);
    chk("unmapped read response", {30'h0, rtc_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
    axi_write(8'h3c, 32'h1234_5678, r);
    chk("unmapped write response", {30'h0, rtc_pkg::RESP_SLVERR}, {30'h0, r});
  endtask : check_reset_state
  task automatic check_key_lock;
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0080);
    rd_chk("control while locked", rtc_pkg::OFS_CTRL, 32'h0000_0000);
    unlock();
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0080);
    rd_chk("control after key pair", rtc_pkg::OFS_CTRL, 32'h0000_0080);
    wr(rtc_pkg::OFS_KEY, {24'h0, rtc_pkg::KEY_RELOCK});
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk("control after relock", rtc_pkg::OFS_CTRL, 32'h0000_0080);
  endtask : check_key_lock
  // Binary counter loads all ones in init, then counts down per async tick
  task automatic check_binary_mode;
    logic [31:0] d;
    logic [1:0] r;
    unlock();
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0081);
    poll("init ready", rtc_pkg::OFS_CTRL, 32'h0000_0002, 32'h0000_0002);
    wr(rtc_pkg::OFS_PRESC, 32'h0001_0003);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0085);
    rd_chk("subsecond after binary select", rtc_pkg::OFS_SUBSEC, rtc_pkg::SS_RELOAD);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0084);
    repeat (200) @(posedge clk_sys);
    axi_read(rtc_pkg::OFS_SUBSEC, d, r);
    chk("live subsecond counting down", 32'h1, {31'h0, (d < 32'hffff_ffff) && (d > 32'hffff_ffe0)});
  endtask : check_binary_mode
  // Every field masked: one alarm per calendar second, cleared by software
  task automatic check_alarm_all_masked;
    int n;
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0085);
    poll("init ready", rtc_pkg::OFS_CTRL, 32'h0000_0002, 32'h0000_0002);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0081);
    // Leaving binary mode keeps the counter's upper bits; reload the divider
    wr(rtc_pkg::OFS_PRESC, 32'h0001_0003);
    wr(rtc_pkg::OFS_ALM_A_TIME, 32'h8080_8080);
    rd_chk("alarm a masks", rtc_pkg::OFS_ALM_A_TIME, 32'h8080_8080);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_1580);
    tick_period(n);
    chk("cycles per second", 32'd64, n);
    for (n = 0; n < 2000 && irq_a !== 1'b1; n++) @(posedge clk_sys);
    if (n == 2000)
      give_up("alarm a interrupt");
    chk("alarm a interrupt", 32'h3, {30'h0, irq_a, wakeup});
    chk("alarm b quiet", 32'h0, {31'h0, irq_b});
    rd_chk("flag and write lock", rtc_pkg::OFS_STAT, 32'h0000_0009);
    chk("alarm output", 32'h1, {31'h0, alarm_out});
    wr(rtc_pkg::OFS_ALM_A_TIME, 32'h0000_0000);
    rd_chk("alarm a guarded", rtc_pkg::OFS_ALM_A_TIME, 32'h8080_8080);
    wr(rtc_pkg::OFS_STAT, 32'h0000_0001);
    chk("interrupt after clear", 32'h0, {31'h0, irq_a});
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0480);
    poll("write allowed", rtc_pkg::OFS_STAT, 32'h0000_000c, 32'h0000_000c);
    wr(rtc_pkg::OFS_ALM_A_TIME, 32'h0000_0080);
    rd_chk("alarm a rewritten", rtc_pkg::OFS_ALM_A_TIME, 32'h0000_0080);
  endtask : check_alarm_all_masked
  // Mixed mode, three low bits: one second per eight async ticks
  task automatic check_mixed_mode;
    int n;
    wr(rtc_pkg::OFS_CTRL, 32'h0000_0081);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_00ad);
    wr(rtc_pkg::OFS_CTRL, 32'h0000_00ac);
    tick_period(n);
    chk("cycles per mixed second", 32'd128, n);
  endtask : check_mixed_mode
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check_reset_state();
    check_key_lock();
    check_binary_mode();
    check_alarm_all_masked();
    check_mixed_mode();
    report_and_stop();
  end
endmodule : testbench
